// [hw/tocf_consts.vh]
`ifndef TOCF_CONSTS_VH
`define TOCF_CONSTS_VH

`define TOCF_ADDR_W 28
`define TOCF_OFS_CTRL 28'hFFFF590
`define TOCF_OFS_OPTION 28'hFFFF594
`define TOCF_OFS_WRAP_CLR 28'hFFFF598
`define TOCF_OFS_OUTCTL 28'hFFFF59C
`define TOCF_OFS_EDGE 28'hFFFF5A0
`define TOCF_OFS_CCR0 28'hFFFF5A4
`define TOCF_OFS_CCR1 28'hFFFF5A8
`define TOCF_OFS_CNT 28'hFFFF5AC
`define TOCF_OFS_NFC0 28'hFFFFB00
`define TOCF_OFS_NFC1 28'hFFFFB04

`define TOCF_CTRL_MODE_LSB 0
`define TOCF_CTRL_CLK_LSB 3
`define TOCF_CTRL_EXT_BIT 6
`define TOCF_CTRL_CE_BIT 7
`define TOCF_OPT_WRAP_BIT 0
`define TOCF_OPT_CAP0_BIT 1
`define TOCF_OPT_CAP1_BIT 2
`define TOCF_NFC_STS_BIT 6
`define TOCF_NFC_MASK 8'h47

`define TOCF_MODE_INTERVAL 3'h0
`define TOCF_MODE_EXT_TRIG 3'h1
`define TOCF_MODE_ONE_SHOT 3'h2
`define TOCF_MODE_PWM 3'h3
`define TOCF_MODE_FREE 3'h4
`define TOCF_MODE_EVENT 3'h5
`define TOCF_MODE_PULSE_W 3'h6

`define TOCF_CLK_SLOW_SEL 3'h3
`define TOCF_CNT_MAX 16'hFFFF
`define TOCF_CNT_ZERO 16'h0000
`define TOCF_RESET_BYTE 8'h00

`endif

// [hw/tocf_noise_filter.v]
`timescale 1ns/1ps
`include "tocf_consts.vh"

module tocf_noise_filter (
  input wire clock_i,
  input wire rst_b_i,
  input wire raw_i,
  input wire bypass_i,
  input wire [7:0] ctrl_i,
  output reg level_o
);
  reg sync1_reg;
  reg sync2_reg;
  reg [5:0] div_reg;
  reg [2:0] hist_reg;
  reg tick_reg;
  reg [5:0] mask;
  wire [2:0] clk_sel;
  wire two_sel;
  wire agree;

  assign clk_sel = ctrl_i[2:0];
  assign two_sel = ctrl_i[`TOCF_NFC_STS_BIT];

  // Prohibited codes fall back to the undivided clock
  always @* begin
    case (clk_sel)
      3'h0: mask = 6'h00;
      3'h1: mask = 6'h01;
      3'h2: mask = 6'h03;
      3'h3: mask = 6'h0F;
      3'h4: mask = 6'h1F;
      3'h5: mask = 6'h3F;
      default: mask = 6'h00;
    endcase
  end

  assign agree = two_sel ? (hist_reg[1] == hist_reg[0])
                         : (hist_reg[2] == hist_reg[1]) && (hist_reg[1] == hist_reg[0]);

  always @(posedge clock_i) begin
    if (!rst_b_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      div_reg <= 6'h00;
      hist_reg <= 3'h0;
      tick_reg <= 1'b0;
      level_o <= 1'b0;
    end else begin
      sync1_reg <= raw_i;
      sync2_reg <= sync1_reg;
      div_reg <= div_reg + 6'h01;
      tick_reg <= 1'b0;
      if ((div_reg & mask) == mask) begin
        hist_reg <= {hist_reg[1:0], sync2_reg};
        tick_reg <= 1'b1;
      end
      if (bypass_i)
        level_o <= sync2_reg;
      else if (tick_reg && agree)
        level_o <= hist_reg[0];
    end
  end
endmodule // tocf_noise_filter

// [hw/tocf_top.v]
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "tocf_consts.vh"

module tocf_top (
  input wire clock_i,
  input wire rst_b_i,
  input wire [27:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire [1:0] capture_input_pin_i,
  output reg timer_out_0_o,
  output reg timer_out_1_o,
  output reg wrap_irq_o
);
  reg [7:0] ctrl_reg;
  reg [2:0] option_reg;
  reg [3:0] output_control_reg;
  reg [3:0] edge_sel_reg;
  reg [15:0] capture_compare_0_reg;
  reg [15:0] capture_compare_1_reg;
  reg [15:0] count_reg;
  reg [7:0] capture_filter_ctrl_0_reg;
  reg [7:0] capture_filter_ctrl_1_reg;
  reg [6:0] prescale_reg;
  reg [1:0] level_d_reg;
  reg ext_d_reg;
  reg ce_d_reg;
  reg run_reg;
  reg primed_reg;
  reg wave0_reg;
  reg wave1_reg;
  reg [31:0] rd_next;
  wire [1:0] filt_level;
  wire [1:0] valid_edge;
  wire [2:0] mode;
  wire [2:0] clk_sel;
  wire ext_clk;
  wire count_enable;
  wire [6:0] pre_mask;
  wire tick;
  wire match0;
  wire match1;
  wire wrap;
  wire cap_mode0;
  wire cap_mode1;
  wire pin0_is_input;
  wire trig_mode;
  wire trigger;
  wire ce_rise;
  wire slow_clk;
  wire wr_go;
  wire byte0;
  wire bit_clear;
  wire byte_clear;
  wire wrap_set;
  wire pw_mode;
  wire oe0;
  wire ol0;
  wire oe1;
  wire ol1;

  assign mode = ctrl_reg[`TOCF_CTRL_MODE_LSB+2:`TOCF_CTRL_MODE_LSB];
  assign clk_sel = ctrl_reg[`TOCF_CTRL_CLK_LSB+2:`TOCF_CTRL_CLK_LSB];
  assign ext_clk = ctrl_reg[`TOCF_CTRL_EXT_BIT];
  assign count_enable = ctrl_reg[`TOCF_CTRL_CE_BIT];
  assign cap_mode0 = option_reg[`TOCF_OPT_CAP0_BIT];
  assign cap_mode1 = option_reg[`TOCF_OPT_CAP1_BIT];
  assign oe0 = output_control_reg[0];
  assign ol0 = output_control_reg[1];
  assign oe1 = output_control_reg[2];
  assign ol1 = output_control_reg[3];
  assign pw_mode = (mode == `TOCF_MODE_PULSE_W);
  assign trig_mode = (mode == `TOCF_MODE_EXT_TRIG) || (mode == `TOCF_MODE_ONE_SHOT);

  // Pin 0 doubles as event clock or trigger input; the filter would eat short events
  assign pin0_is_input = ext_clk || (mode == `TOCF_MODE_EVENT) || trig_mode;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      tocf_noise_filter u_filter (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .raw_i(capture_input_pin_i[ch]),
        .bypass_i((ch == 0) ? pin0_is_input : 1'b0),
        .ctrl_i((ch == 0) ? capture_filter_ctrl_0_reg : capture_filter_ctrl_1_reg),
        .level_o(filt_level[ch])
      );
      // Edge select: 00 none, 01 rising, 10 falling, 11 both
      assign valid_edge[ch] = (edge_sel_reg[2*ch] & filt_level[ch] & ~level_d_reg[ch]) |
                              (edge_sel_reg[2*ch+1] & ~filt_level[ch] & level_d_reg[ch]);
    end
  endgenerate

  assign pre_mask = 7'h7F >> (3'h7 - clk_sel);
  assign tick = run_reg && (ext_clk ? (filt_level[0] & ~ext_d_reg)
                                    : ((prescale_reg & pre_mask) == pre_mask));
  assign match0 = (count_reg == capture_compare_0_reg);
  assign match1 = (count_reg == capture_compare_1_reg);
  assign wrap = tick && (count_reg == `TOCF_CNT_MAX) && !primed_reg;
  assign trigger = trig_mode && valid_edge[0];
  assign ce_rise = count_enable && !ce_d_reg;
  assign slow_clk = ext_clk || (clk_sel >= `TOCF_CLK_SLOW_SEL);

  assign wr_go = avs_write_i && !avs_waitrequest_o;
  assign byte0 = avs_byteenable_i[0];
  assign bit_clear = wr_go && byte0 && (avs_address_i == `TOCF_OFS_WRAP_CLR) &&
                     avs_writedata_i[`TOCF_OPT_WRAP_BIT];
  assign byte_clear = wr_go && byte0 && (avs_address_i == `TOCF_OFS_OPTION) &&
                      !avs_writedata_i[`TOCF_OPT_WRAP_BIT];
  assign wrap_set = wrap;

  // One wait cycle: request seen, then waitrequest drops for exactly one cycle
  always @(posedge clock_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= 1'b1;
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        if (avs_read_i)
          avs_readdata_o <= rd_next;
      end
    end
  end

  always @* begin
    rd_next = 32'h00000000;
    case (avs_address_i)
      `TOCF_OFS_CTRL: rd_next = {24'h000000, ctrl_reg};
      `TOCF_OFS_OPTION: rd_next = {29'h00000000, option_reg};
      `TOCF_OFS_OUTCTL: rd_next = {28'h0000000, output_control_reg};
      `TOCF_OFS_EDGE: rd_next = {28'h0000000, edge_sel_reg};
      `TOCF_OFS_CCR0: rd_next = {16'h0000, capture_compare_0_reg};
      `TOCF_OFS_CCR1: rd_next = {16'h0000, capture_compare_1_reg};
      `TOCF_OFS_CNT: rd_next = {16'h0000, count_reg};
      `TOCF_OFS_NFC0: rd_next = {24'h000000, capture_filter_ctrl_0_reg};
      `TOCF_OFS_NFC1: rd_next = {24'h000000, capture_filter_ctrl_1_reg};
      default: rd_next = 32'h00000000;
    endcase
  end

  // Register writes; hardware capture beats a software write to the same register
  always @(posedge clock_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= `TOCF_RESET_BYTE;
      option_reg <= 3'h0;
      output_control_reg <= 4'h0;
      edge_sel_reg <= 4'h0;
      capture_compare_0_reg <= `TOCF_CNT_ZERO;
      capture_compare_1_reg <= `TOCF_CNT_ZERO;
      capture_filter_ctrl_0_reg <= `TOCF_RESET_BYTE;
      capture_filter_ctrl_1_reg <= `TOCF_RESET_BYTE;
    end else begin
      if (wr_go && byte0) begin
        case (avs_address_i)
          `TOCF_OFS_CTRL: ctrl_reg <= avs_writedata_i[7:0];
          `TOCF_OFS_OPTION: option_reg[2:1] <= avs_writedata_i[2:1];
          `TOCF_OFS_OUTCTL: output_control_reg <= avs_writedata_i[3:0];
          `TOCF_OFS_EDGE: edge_sel_reg <= avs_writedata_i[3:0];
          // Reserved bits are not stored and read back as zero
          `TOCF_OFS_NFC0: capture_filter_ctrl_0_reg <= avs_writedata_i[7:0] & `TOCF_NFC_MASK;
          `TOCF_OFS_NFC1: capture_filter_ctrl_1_reg <= avs_writedata_i[7:0] & `TOCF_NFC_MASK;
          default: ;
        endcase
      end
      if (wr_go && (avs_address_i == `TOCF_OFS_CCR0) && byte0)
        capture_compare_0_reg <= avs_writedata_i[15:0];
      if (wr_go && (avs_address_i == `TOCF_OFS_CCR1) && byte0)
        capture_compare_1_reg <= avs_writedata_i[15:0];
      if (run_reg && valid_edge[0] && (pw_mode || (mode == `TOCF_MODE_FREE && cap_mode0)) &&
          !pin0_is_input)
        capture_compare_0_reg <= count_reg;
      if (run_reg && valid_edge[1] && (pw_mode || (mode == `TOCF_MODE_FREE && cap_mode1)))
        capture_compare_1_reg <= count_reg;
      // Set wins over either clear
      option_reg[0] <= wrap_set | (option_reg[0] & ~(bit_clear | byte_clear));
    end
  end

  // Counter and waveform generation
  always @(posedge clock_i) begin
    if (!rst_b_i) begin
      count_reg <= `TOCF_CNT_ZERO;
      prescale_reg <= 7'h00;
      level_d_reg <= 2'h0;
      ext_d_reg <= 1'b0;
      ce_d_reg <= 1'b0;
      run_reg <= 1'b0;
      primed_reg <= 1'b0;
      wave0_reg <= 1'b0;
      wave1_reg <= 1'b0;
      wrap_irq_o <= 1'b0;
      timer_out_0_o <= 1'b0;
      timer_out_1_o <= 1'b0;
    end else begin
      level_d_reg <= filt_level;
      ext_d_reg <= filt_level[0];
      ce_d_reg <= count_enable;
      prescale_reg <= count_enable ? prescale_reg + 7'h01 : 7'h00;
      wrap_irq_o <= wrap;
      if (!count_enable) begin
        run_reg <= 1'b0;
        primed_reg <= 1'b0;
        count_reg <= `TOCF_CNT_ZERO;
        wave0_reg <= 1'b0;
        wave1_reg <= 1'b0;
      end else if (ce_rise) begin
        run_reg <= !trig_mode;
        // Slow clocks start one step before zero, so an early capture sees the maximum
        primed_reg <= slow_clk;
        count_reg <= slow_clk ? `TOCF_CNT_MAX : `TOCF_CNT_ZERO;
        wave0_reg <= 1'b1;
        wave1_reg <= (mode == `TOCF_MODE_INTERVAL) || (mode == `TOCF_MODE_EVENT) ||
                     (mode == `TOCF_MODE_FREE);
      end else begin
        if (trigger) begin
          run_reg <= 1'b1;
          count_reg <= `TOCF_CNT_ZERO;
        end else if (tick) begin
          primed_reg <= 1'b0;
          if (pw_mode && valid_edge != 2'h0)
            count_reg <= `TOCF_CNT_ZERO;
          else if (mode != `TOCF_MODE_FREE && !pw_mode && match0)
            count_reg <= `TOCF_CNT_ZERO;
          else
            count_reg <= count_reg + 16'h0001;
          case (mode)
            `TOCF_MODE_INTERVAL, `TOCF_MODE_EVENT: if (match0) wave1_reg <= ~wave1_reg;
            `TOCF_MODE_EXT_TRIG: begin
              if (match0) wave0_reg <= ~wave0_reg;
              wave1_reg <= (count_reg >= capture_compare_1_reg) && !match0;
            end
            `TOCF_MODE_ONE_SHOT: begin
              wave1_reg <= (count_reg >= capture_compare_1_reg) && !match0;
              if (match0) run_reg <= 1'b0;
            end
            `TOCF_MODE_PWM: wave1_reg <= (count_reg >= capture_compare_1_reg) && !match0;
            `TOCF_MODE_FREE: begin
              if (match0 && !cap_mode0) wave0_reg <= ~wave0_reg;
              if (match1 && !cap_mode1) wave1_reg <= ~wave1_reg;
            end
            default: ;
          endcase
        end else if (pw_mode && run_reg && valid_edge != 2'h0) begin
          count_reg <= `TOCF_CNT_ZERO;
        end
      end
      if (pw_mode) begin
        timer_out_0_o <= 1'b0;
        timer_out_1_o <= 1'b0;
      end else begin
        timer_out_0_o <= (oe0 && count_enable && wave0_used(1'b0)) ?
                         (ol0 ^ wave0_reg) : ol0;
        timer_out_1_o <= (oe1 && count_enable) ? (ol1 ^ wave1_reg) : ol1;
      end
    end
  end

  // Only external-trigger mode and free-running compare use pin 0
  function wave0_used;
    input dummy;
    begin
      wave0_used = (mode == `TOCF_MODE_EXT_TRIG) ||
                   ((mode == `TOCF_MODE_FREE) && !cap_mode0);
    end
  endfunction
endmodule // tocf_top

// [testbench/tocf_top_chk.sv]
`timescale 1ns/1ps
`include "tocf_consts.vh"
module tocf_chk (
  input wire clock_i,
  input wire rst_b_i,
  input wire [27:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire wrap_irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire taken = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  wire rd_take = avs_read_i && avs_waitrequest_o;
  wire mapped = avs_address_i inside {`TOCF_OFS_CTRL, `TOCF_OFS_OPTION, `TOCF_OFS_WRAP_CLR,
    `TOCF_OFS_OUTCTL, `TOCF_OFS_EDGE, `TOCF_OFS_CCR0, `TOCF_OFS_CCR1, `TOCF_OFS_CNT,
    `TOCF_OFS_NFC0, `TOCF_OFS_NFC1};
  wait_answer_a: assert property (taken |=> !avs_waitrequest_o)
    else $error("request not answered in the next cycle");
  wait_idle_a: assert property (!taken |=> avs_waitrequest_o)
    else $error("waitrequest low without a request");
  readdata_hold_a: assert property (!rd_take |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  irq_pulse_a: assert property (wrap_irq_o |=> !wrap_irq_o)
    else $error("wrap request longer than one cycle");
  unmapped_zero_a: assert property (rd_take && !mapped |=> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  filter_mask_a: assert property (rd_take && (avs_address_i == `TOCF_OFS_NFC0 ||
    avs_address_i == `TOCF_OFS_NFC1) |=> (avs_readdata_o & 32'hFFFFFFB8) == 32'h0)
    else $error("reserved filter bits read nonzero");
  clr_reads_zero_a: assert property (rd_take && avs_address_i == `TOCF_OFS_WRAP_CLR
    |=> avs_readdata_o == 32'h0)
    else $error("clear register read nonzero");
  count_width_a: assert property (rd_take && avs_address_i inside {`TOCF_OFS_CCR0,
    `TOCF_OFS_CCR1, `TOCF_OFS_CNT} |=> avs_readdata_o[31:16] == 16'h0)
    else $error("count read wider than 16 bits");
endmodule // tocf_chk
bind tocf_top tocf_chk tocf_chk_i (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .wrap_irq_o(wrap_irq_o));

// [testbench/tocf_pulse_src.sv]
`timescale 1ns/1ps
module tocf_pulse_src (
  input wire clock_i,
  output logic [1:0] pin_o
);
  initial pin_o = 2'h0;
  // Whole-cycle pulses only; pins idle low, as with a pull-down source
  task pulse(input int ch, input int w);
    @(posedge clock_i);
    pin_o <= pin_o | (2'h1 << ch);
    repeat (w) @(posedge clock_i);
    pin_o <= pin_o & ~(2'h1 << ch);
  endtask
endmodule // tocf_pulse_src

// [testbench/testbench.sv]
`timescale 1ns/1ps
`include "tocf_consts.vh"
module testbench;
  localparam int TP [6] = '{1, 2, 4, 16, 32, 64};
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [27:0] adr = 28'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [1:0] pins;
  logic out0;
  logic out1;
  logic irq;
  logic [31:0] got;
  int fails = 0;
  int checked = 0;
  always #12.5 clock_i = ~clock_i;
  tocf_top tocf_top_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .capture_input_pin_i(pins),
    .timer_out_0_o(out0), .timer_out_1_o(out1), .wrap_irq_o(irq));
  tocf_pulse_src tocf_pulse_src_i (.clock_i(clock_i), .pin_o(pins));
  task end_of_test;
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [27:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clock_i);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    be <= b;
    do begin
      @(posedge clock_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    got = rdat;
    if (n >= 50) fails++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task wb(input logic [27:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task rb(input logic [27:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  task outs(input int n, input logic [31:0] e);
    repeat (n) @(posedge clock_i);
    chk({30'h0, out1, out0}, e);
  endtask
  task watch(input int n, output logic [1:0] hi, output logic [1:0] lo);
    hi = 2'h0;
    lo = 2'h0;
    repeat (n) begin
      @(posedge clock_i);
      hi = hi | {out1, out0};
      lo = lo | ~{out1, out0};
    end
  endtask
  task t_regs;
    rb(`TOCF_OFS_NFC0);
    chk(got, 32'h0);
    outs(1, 32'h0);
    wb(`TOCF_OFS_NFC0, 32'hFF);
    rb(`TOCF_OFS_NFC0);
    chk(got, 32'h47);
    bus(1'b1, `TOCF_OFS_NFC1, 32'h41, 4'hE);
    rb(`TOCF_OFS_NFC1);
    chk(got, 32'h0);
    rb(28'h0000100);
    chk(got, 32'h0);
  endtask
  task t_outputs;
    wb(`TOCF_OFS_CCR0, 32'hFF);
    wb(`TOCF_OFS_OUTCTL, 32'hA);
    outs(3, 32'h3);
    wb(`TOCF_OFS_OUTCTL, 32'hF);
    outs(3, 32'h3);
    wb(`TOCF_OFS_OUTCTL, 32'h5);
    outs(3, 32'h0);
    wb(`TOCF_OFS_CTRL, 32'h80);
    outs(4, 32'h2);
    outs(300, 32'h0);
    wb(`TOCF_OFS_CTRL, 32'h0);
    wb(`TOCF_OFS_OUTCTL, 32'hF);
    wb(`TOCF_OFS_CTRL, 32'h80);
    outs(4, 32'h1);
    wb(`TOCF_OFS_CTRL, 32'h86);
    outs(4, 32'h0);
    wb(`TOCF_OFS_CTRL, 32'h0);
  endtask
  task t_modes;
    logic [1:0] hi;
    logic [1:0] lo;
    wb(`TOCF_OFS_OUTCTL, 32'h5);
    wb(`TOCF_OFS_CCR0, 32'hF);
    wb(`TOCF_OFS_CCR1, 32'h8);
    wb(`TOCF_OFS_EDGE, 32'h1);
    wb(`TOCF_OFS_CTRL, 32'h83);
    outs(4, 32'h0);
    watch(40, hi, lo);
    chk({30'h0, hi[1], lo[1]}, 32'h3);
    chk({30'h0, hi[0], lo[0]}, 32'h1);
    // Trigger modes stay quiet until pin 0 sees its edge
    for (int m = 1; m < 3; m++) begin
      wb(`TOCF_OFS_CTRL, 32'h0);
      wb(`TOCF_OFS_CTRL, 32'h80 | m);
      watch(20, hi, lo);
      chk({30'h0, hi[1], lo[1]}, 32'h1);
      tocf_pulse_src_i.pulse(0, 1);
      watch(40, hi, lo);
      chk({30'h0, hi[1], lo[1]}, 32'h3);
      chk({30'h0, hi[0], lo[0]}, (m == 1) ? 32'h3 : 32'h1);
    end
    wb(`TOCF_OFS_CTRL, 32'h0);
    wb(`TOCF_OFS_OPTION, 32'h2);
    wb(`TOCF_OFS_CCR1, 32'h10);
    wb(`TOCF_OFS_CTRL, 32'h84);
    outs(4, 32'h2);
    watch(40, hi, lo);
    chk({30'h0, hi[1], lo[1]}, 32'h3);
    chk({30'h0, hi[0], lo[0]}, 32'h1);
    wb(`TOCF_OFS_CTRL, 32'h0);
  endtask
  task trial(input int ch, input logic [7:0] nfc, input int t, input int w, input logic acc);
    wb(`TOCF_OFS_CTRL, 32'h0);
    wb(ch ? `TOCF_OFS_NFC1 : `TOCF_OFS_NFC0, {24'h0, nfc});
    repeat (4 * t) @(posedge clock_i);
    wb(`TOCF_OFS_CTRL, 32'h84);
    wb(ch ? `TOCF_OFS_CCR1 : `TOCF_OFS_CCR0, 32'h0);
    tocf_pulse_src_i.pulse(ch, w);
    repeat (3 * t + 12) @(posedge clock_i);
    rb(ch ? `TOCF_OFS_CCR1 : `TOCF_OFS_CCR0);
    chk({31'h0, got[15:0] != 16'h0}, {31'h0, acc});
  endtask
  task t_filter;
    wb(`TOCF_OFS_NFC0, 32'h0);
    wb(`TOCF_OFS_OPTION, 32'h6);
    wb(`TOCF_OFS_EDGE, 32'h5);
    wb(`TOCF_OFS_CTRL, 32'h84);
    trial(0, 8'h00, 1, 1, 1'b0);
    trial(0, 8'h00, 1, 3, 1'b1);
    trial(0, 8'h40, 1, 2, 1'b1);
    for (int c = 1; c < 6; c++) begin
      trial(0, 8'h40 | 8'(c), TP[c], TP[c] - 1, 1'b0);
      trial(0, 8'h40 | 8'(c), TP[c], 2 * TP[c], 1'b1);
    end
    trial(1, 8'h00, 1, 3, 1'b1);
  endtask
  task t_wrap;
    rb(`TOCF_OFS_CNT);
    // Counter ticks every clock, so the next bit-clear can land on the wrapping edge
    repeat (32'h0000FFFB - got) @(posedge clock_i);
    wb(`TOCF_OFS_WRAP_CLR, 32'h1);
    @(posedge clock_i);
    chk({31'h0, irq}, 32'h1);
    rb(`TOCF_OFS_OPTION);
    chk(got & 32'h1, 32'h1);
    bus(1'b1, `TOCF_OFS_OPTION, 32'h6, 4'hE);
    wb(`TOCF_OFS_OPTION, 32'h7);
    rb(`TOCF_OFS_OPTION);
    chk(got & 32'h1, 32'h1);
    wb(`TOCF_OFS_WRAP_CLR, 32'h1);
    rb(`TOCF_OFS_OPTION);
    chk(got & 32'h1, 32'h0);
    bus(1'b1, `TOCF_OFS_OPTION, 32'h6, 4'h1);
    rb(`TOCF_OFS_OPTION);
    chk(got & 32'h1, 32'h0);
    rb(`TOCF_OFS_WRAP_CLR);
    chk(got, 32'h0);
  endtask
  task t_event;
    wb(`TOCF_OFS_CTRL, 32'h0);
    wb(`TOCF_OFS_OPTION, 32'h0);
    wb(`TOCF_OFS_CCR0, 32'hFF);
    wb(`TOCF_OFS_NFC0, 32'h05);
    wb(`TOCF_OFS_CTRL, 32'hC5);
    // Slowest filter would swallow these one-cycle pulses unless it is bypassed
    repeat (3) begin
      tocf_pulse_src_i.pulse(0, 1);
      repeat (4) @(posedge clock_i);
    end
    repeat (8) @(posedge clock_i);
    rb(`TOCF_OFS_CNT);
    chk(got, 32'h2);
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_regs;
    t_outputs;
    t_modes;
    t_filter;
    t_wrap;
    t_event;
    end_of_test;
  end
  initial begin
    #2250000;
    fails++;
    end_of_test;
  end
endmodule // testbench
